// *** hdl/dpg_gpio.sv ***
// Purpose: two 8-bit gpio ports with change detect, over axi4-lite
// Assumes: pins asynchronous, peripherals on the core clock
// Notes:   comparator and reference analog parts are not modelled
// Overview of operation
// - second port direction one floats the pin, zero drives latch
// - second port data read returns pins, write goes to latch
// - port writes sample pins, modify selected bits, store in latch
// - enabled alternate function overrides second port direction
// - clearing option bit 7 enables all second port pull-ups
// - pull-up off while the pin is an output
// - pull-ups disabled after power-on reset
// - change detect covers upper four inputs, outputs excluded
// - mismatch against last-read value ORed into flag bit 0
// - change flag can wake the core from sleep
// - any second port read or low-byte write refreshes the compare value
// - persisting mismatch keeps setting flag; read before clearing
// - a change during a port read still sets the flag
// - first port bit 4 is open drain, pulls low only
// - first port bit 5 input only, optional active-low master clear
// - oscillator output pin may carry a quarter rate clock
// - unimplemented register bits read as zero
// - first port direction one floats the pin, zero drives latch
// - first port pins used as comparator inputs read as zero
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module dpg_gpio
   import dpg_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic [dpg_pkg::AW-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [dpg_pkg::AW-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic [7:0]            pa_in,
   output logic [7:0]                 pa_out,
   output logic [7:0]                 pa_oe,
   input  wire logic [7:0]            pb_in,
   output logic [7:0]                 pb_out,
   output logic [7:0]                 pb_oe,
   output logic [7:0]                 pb_pullup,
   input  wire logic [7:0]            alt_out,
   input  wire logic [7:0]            alt_oe,
   input  wire logic                  sleep,
   output logic                       wake,
   output logic                       port_change_irq,
   output logic                       master_clear_req
);
   import dpg_pkg::*;

   typedef struct packed {
      logic             aw_v;
      logic [IDX_W-1:0] aw_i;
      logic             aw_ok;
      logic             w_v;
      logic [31:0]      wd;
      logic [3:0]       ws;
      logic             bv;
      logic [1:0]       br;
      logic             rv;
      logic [7:0]       rd;
      logic [1:0]       rr;
      logic [7:0]       pa_lat;
      logic [7:0]       pa_dir;
      logic [7:0]       pb_lat;
      logic [7:0]       pb_dir;
      logic [7:0]       opt;
      logic [7:0]       intc;
      logic [7:0]       cmp;
      logic [7:0]       vref;
      logic [7:0]       alt;
      logic [7:0]       cfg;
      logic [3:0]       old;
   } dpg_state_t;

   localparam dpg_state_t ST_RST = '{
      aw_i: '0, wd: '0, ws: '0, br: RESP_OKAY, rd: '0, rr: RESP_OKAY,
      pa_lat: RST_LAT, pa_dir: RST_TRIS, pb_lat: RST_LAT, pb_dir: RST_TRIS,
      opt: RST_OPT, intc: RST_INTC, cmp: RST_CMP, vref: RST_VREF,
      alt: RST_ALT, cfg: RST_CFG, old: '0, default: 1'b0};

   dpg_state_t   s_q;
   dpg_state_t   s_d;
   logic [15:0]  pin_s;
   logic [7:0]   pa_s;
   logic [7:0]   pb_s;
   logic [7:0]   pa_rd;
   logic         qclk;
   logic         mism;
   logic         pb_touch;

   function automatic logic mapped(input logic [IDX_W-1:0] i);
      unique case (i)
         IDX_PA, IDX_PB, IDX_INTC, IDX_CMP, IDX_OPT,
         IDX_TRA, IDX_TRB, IDX_VREF, IDX_ALT, IDX_CFG: mapped = 1'b1;
         default:                                      mapped = 1'b0;
      endcase
   endfunction : mapped

   function automatic logic addr_ok(input logic [AW-1:0] a);
      addr_ok = (a[AW-1:IDX_W+2] == '0) && mapped(a[IDX_W+1:2]);
   endfunction : addr_ok

   // pins first, then the bits selected by the mask replaced
   function automatic logic [7:0] rmw(input logic [7:0] pins,
                                      input logic [7:0] val,
                                      input logic [7:0] m);
      rmw = (pins & ~m) | (val & m);
   endfunction : rmw

   dpg_sync #(
      .W    (16)
   ) u_sync (
      .clk  (clk),
      .rst_n(rst_n),
      .d_i  ({pb_in, pa_in}),
      .q_o  (pin_s)
   );
   assign pa_s = pin_s[7:0];
   assign pb_s = pin_s[15:8];

   dpg_qdiv #(
      .DIV   (QDIV)
   ) u_qdiv (
      .clk   (clk),
      .rst_n (rst_n),
      .tick_o(),
      .wave_o(qclk)
   );

   // comparator modes other than off claim the low four pins as analog
   // pins held as analog inputs read zero, the upper four stay digital
   assign pa_rd = pa_s & ((s_q.cmp[2:0] == CM_OFF) ? 8'hff : ~ANA_MASK);

   // second port pin drivers
   for (genvar i = 0; i < 8; i++) begin : g_pb
      always_comb begin
         if (s_q.alt[i]) begin
            pb_oe[i]  = alt_oe[i];
            pb_out[i] = alt_out[i];
         end else begin
            pb_oe[i]  = ~s_q.pb_dir[i];
            pb_out[i] = s_q.pb_lat[i];
         end
         pb_pullup[i] = ~s_q.opt[OPT_PUN_BIT] & ~pb_oe[i];
      end
   end

   // first port pin drivers
   always_comb begin
      pa_oe  = ~s_q.pa_dir;
      pa_out = s_q.pa_lat;
      pa_out[PA_OD_BIT] = 1'b0;
      pa_oe[PA_OD_BIT]  = ~s_q.pa_dir[PA_OD_BIT] & ~s_q.pa_lat[PA_OD_BIT];
      pa_oe[PA_IN_BIT]  = 1'b0;
      if (s_q.cfg[CFG_QCLK]) begin
         pa_oe[PA_OSC_BIT]  = 1'b1;
         pa_out[PA_OSC_BIT] = qclk;
      end
   end

   // only inputs take part; an output pin never compares
   assign mism = |((pb_s[7:4] ^ s_q.old) & ~pb_oe[7:4]);

   assign master_clear_req = s_q.cfg[CFG_MASTER_CLEAR_N] & ~pa_s[PA_IN_BIT];
   assign port_change_irq  = s_q.intc[FLAG_BIT] & s_q.intc[IE_BIT];
   assign wake             = sleep & port_change_irq;

   assign s_axi_awready = ~s_q.aw_v;
   assign s_axi_wready  = ~s_q.w_v;
   assign s_axi_bvalid  = s_q.bv;
   assign s_axi_bresp   = s_q.br;
   assign s_axi_arready = ~s_q.rv;
   assign s_axi_rvalid  = s_q.rv;
   assign s_axi_rresp   = s_q.rr;
   assign s_axi_rdata   = {24'h000000, s_q.rd};

   always_comb begin
      logic [7:0]       m;
      logic [7:0]       rv;
      logic [IDX_W-1:0] ri;
      m        = 8'hff;
      rv       = 8'h00;
      ri       = s_axi_araddr[IDX_W+1:2];
      pb_touch = 1'b0;
      s_d      = s_q;
      if (s_axi_awvalid && s_axi_awready) begin
         s_d.aw_v  = 1'b1;
         s_d.aw_i  = s_axi_awaddr[IDX_W+1:2];
         s_d.aw_ok = addr_ok(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_d.w_v = 1'b1;
         s_d.wd  = s_axi_wdata;
         s_d.ws  = s_axi_wstrb;
      end
      // write commits once address and data are both in and no answer waits
      if (s_q.aw_v && s_q.w_v && !s_q.bv) begin
         s_d.aw_v = 1'b0;
         s_d.w_v  = 1'b0;
         s_d.bv   = 1'b1;
         s_d.br   = s_q.aw_ok ? RESP_OKAY : RESP_DECERR;
         if (s_q.ws[1]) m = s_q.wd[15:8];
         if (s_q.aw_ok && s_q.ws[0]) begin
            unique case (s_q.aw_i)
               IDX_PA:   s_d.pa_lat = rmw(pa_rd, s_q.wd[7:0], m);
               IDX_PB: begin
                  s_d.pb_lat = rmw(pb_s, s_q.wd[7:0], m);
                  pb_touch   = 1'b1;
               end
               IDX_INTC: s_d.intc   = s_q.wd[7:0];
               IDX_CMP:  s_d.cmp    = s_q.wd[7:0] & CMP_WMASK;
               IDX_OPT:  s_d.opt    = s_q.wd[7:0];
               IDX_TRA:  s_d.pa_dir = s_q.wd[7:0];
               IDX_TRB:  s_d.pb_dir = s_q.wd[7:0];
               IDX_VREF: s_d.vref   = s_q.wd[7:0] & VREF_MASK;
               IDX_ALT:  s_d.alt    = s_q.wd[7:0];
               IDX_CFG:  s_d.cfg    = s_q.wd[7:0] & CFG_MASK;
               default:  s_d.bv     = 1'b1;
            endcase
         end
      end
      if (s_q.bv && s_axi_bready) s_d.bv = 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
         unique case (ri)
            IDX_PA:   rv = pa_rd;
            IDX_PB: begin
               rv       = pb_s;
               pb_touch = addr_ok(s_axi_araddr);
            end
            IDX_INTC: rv = s_q.intc;
            IDX_CMP:  rv = s_q.cmp;
            IDX_OPT:  rv = s_q.opt;
            IDX_TRA:  rv = s_q.pa_dir;
            IDX_TRB:  rv = s_q.pb_dir;
            IDX_VREF: rv = s_q.vref;
            IDX_ALT:  rv = s_q.alt;
            IDX_CFG:  rv = s_q.cfg;
            default:  rv = 8'h00;
         endcase
         if (!addr_ok(s_axi_araddr)) rv = 8'h00;
         s_d.rv = 1'b1;
         s_d.rd = rv;
         s_d.rr = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
      end
      if (s_q.rv && s_axi_rready) s_d.rv = 1'b0;
      // a read in the same cycle as a pin edge still flags it, mism uses the old value
      if (pb_touch) s_d.old = pb_s[7:4];
      // hardware set wins over a software clear in the same cycle
      if (mism) s_d.intc[FLAG_BIT] = 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) s_q <= ST_RST;
      else        s_q <= s_d;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   dir_drive_a: assert property (
      (pb_oe & ~s_q.alt) == (~s_q.pb_dir & ~s_q.alt))
      else $error("second port enable does not follow direction");
   pin_read_a: assert property (
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == {2'h0, IDX_PB, 2'h0})
      |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(pb_s))
      else $error("second port read did not return pins");
   rmw_full_a: assert property (
      (s_q.aw_v && s_q.w_v && !s_q.bv && s_q.aw_ok && s_q.aw_i == IDX_PB
       && s_q.ws == 4'h1) |=> s_q.pb_lat == $past(s_q.wd[7:0]))
      else $error("second port latch missed a write");
   alt_first_a: assert property (
      ((pb_oe ^ alt_oe) & s_q.alt) == 8'h00)
      else $error("alternate function lost control of pin");
   pullup_a: assert property (
      pb_pullup == ({8{~s_q.opt[OPT_PUN_BIT]}} & ~pb_oe))
      else $error("pull-up state wrong");
   flag_set_a: assert property (
      mism |=> s_q.intc[FLAG_BIT])
      else $error("mismatch did not set change flag");
   refresh_a: assert property (
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == {2'h0, IDX_PB, 2'h0})
      |=> s_q.old == $past(pb_s[7:4]) ##1 !$rose(s_q.intc[FLAG_BIT]) || mism)
      else $error("compare value not refreshed on read");
   open_drain_a: assert property (
      !pa_out[PA_OD_BIT] && !(pa_oe[PA_OD_BIT] && s_q.pa_lat[PA_OD_BIT]))
      else $error("open drain pin drove high");
   input_only_a: assert property (
      !pa_oe[PA_IN_BIT])
      else $error("input only pin driven");
   // wake is a level: only owed while sleep and the enable are still up
   wake_path_a: assert property (
      (sleep && s_q.intc[IE_BIT] && mism) ##1 (sleep && s_q.intc[IE_BIT]) |-> wake)
      else $error("change did not wake");
   bhold_a: assert property (
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");
   analog_zero_a: assert property (
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == {2'h0, IDX_PA, 2'h0}
       && s_q.cmp[2:0] != CM_OFF) |=> s_axi_rdata[3:0] == 4'h0)
      else $error("analog pin did not read zero");
   pull_off_a: assert property (
      (pb_pullup & pb_oe) == 8'h00)
      else $error("pull-up left on at an output");
   // a switch-on may land mid period, so only steady running is timed
   osc_rate_a: assert property (
      (s_q.cfg[CFG_QCLK] && $past(s_q.cfg[CFG_QCLK]) && $rose(pa_out[PA_OSC_BIT]))
      |=> (!$rose(pa_out[PA_OSC_BIT]) || !s_q.cfg[CFG_QCLK])[*3])
      else $error("quarter clock ran too fast");
   flag_keep_a: assert property (
      (mism && s_q.aw_v && s_q.w_v && !s_q.bv && s_q.aw_ok && s_q.aw_i == IDX_INTC
       && s_q.ws[0]) |=> s_q.intc[FLAG_BIT])
      else $error("software clear beat a live mismatch");
   pa_dir_a: assert property (
      ((pa_oe ^ ~s_q.pa_dir) & 8'h8f) == 8'h00)
      else $error("first port enable does not follow direction");

   chg_wake_c: cover property (sleep && mism ##1 wake);
   pb_read_c: cover property (pb_touch ##1 (s_axi_rvalid && s_q.rr == RESP_OKAY));
   alt_pin_c: cover property (s_q.alt[3] && alt_oe[3]);
   qclk_c: cover property (s_q.cfg[CFG_QCLK] && pa_oe[PA_OSC_BIT]);
endmodule : dpg_gpio

// *** hdl/dpg_pkg.sv ***
// Purpose: shared constants of the dual gpio port block
// Assumes: registers sit at word index, byte address is four times index
// Notes:   reset values and bit positions used by the top and its helpers
package dpg_pkg;
   localparam int          AW          = 12;
   localparam int          IDX_W       = 8;
   // register indices
   localparam logic [7:0]  IDX_PA      = 8'h05;
   localparam logic [7:0]  IDX_PB      = 8'h06;
   localparam logic [7:0]  IDX_INTC    = 8'h0b;
   localparam logic [7:0]  IDX_CMP     = 8'h1f;
   localparam logic [7:0]  IDX_OPT     = 8'h81;
   localparam logic [7:0]  IDX_TRA     = 8'h85;
   localparam logic [7:0]  IDX_TRB     = 8'h86;
   localparam logic [7:0]  IDX_VREF    = 8'h9f;
   localparam logic [7:0]  IDX_ALT     = 8'ha0;
   localparam logic [7:0]  IDX_CFG     = 8'ha1;
   // reset values
   localparam logic [7:0]  RST_LAT     = 8'h00;
   localparam logic [7:0]  RST_TRIS    = 8'hff;
   localparam logic [7:0]  RST_OPT     = 8'hff;
   localparam logic [7:0]  RST_CMP     = 8'h00;
   localparam logic [7:0]  RST_VREF    = 8'h00;
   localparam logic [7:0]  RST_INTC    = 8'h00;
   localparam logic [7:0]  RST_ALT     = 8'h00;
   localparam logic [7:0]  RST_CFG     = 8'h00;
   // field layout
   localparam logic [7:0]  CMP_WMASK   = 8'h3f;
   localparam logic [7:0]  VREF_MASK   = 8'hef;
   localparam logic [7:0]  CFG_MASK    = 8'h03;
   localparam logic [7:0]  ANA_MASK    = 8'h0f;
   localparam logic [2:0]  CM_OFF      = 3'h7;
   localparam int          OPT_PUN_BIT = 7;
   localparam int          FLAG_BIT    = 0;
   localparam int          IE_BIT      = 3;
   localparam int          CFG_MASTER_CLEAR_N    = 0;
   localparam int          CFG_QCLK    = 1;
   localparam int          PA_OD_BIT   = 4;
   localparam int          PA_IN_BIT   = 5;
   localparam int          PA_OSC_BIT  = 6;
   // timing: quarter clock divides the core clock by this ratio
   localparam int          QDIV        = 4;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_DECERR = 2'h3;
endpackage : dpg_pkg

// *** hdl/dpg_sync.sv ***
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
module dpg_sync #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q_o    <= '0;
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end
endmodule : dpg_sync

// *** hdl/dpg_qdiv.sv ***
// Purpose: divides the core clock for the quarter clock pin
// Assumes: ratio is a power of two, at least two
// Notes:   square wave from the counter msb, tick one cycle per period
`timescale 1ns/100ps
module dpg_qdiv #(
   parameter int DIV = 4
) (
   input  wire logic clk,
   input  wire logic rst_n,
   output logic      tick_o,
   output logic      wave_o
);
   localparam int CW = $clog2(DIV);
   logic [CW-1:0] cnt_q;
   if (DIV < 2 || (DIV & (DIV - 1)) != 0) begin : g_bad
      $error("divide ratio must be a power of two");
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) cnt_q <= '0;
      else        cnt_q <= cnt_q + 1'b1;
   end
   assign tick_o = &cnt_q;
   assign wave_o = cnt_q[CW-1];
endmodule : dpg_qdiv

// *** verif/dpg_pin_model.sv ***
// Purpose: pin side of both ports, keypad and loads
// Assumes: bench gives levels for pins it holds
// Notes:   a free pin with no pull-up shows the inverse of its last level
`timescale 1ns/100ps
module dpg_pin_model (
   input  wire logic       clk,
   input  wire logic [7:0] pa_out,
   input  wire logic [7:0] pa_oe,
   input  wire logic [7:0] pa_ext,
   output logic      [7:0] pa_in,
   input  wire logic [7:0] pb_out,
   input  wire logic [7:0] pb_oe,
   input  wire logic [7:0] pb_pullup,
   input  wire logic [7:0] pb_ext,
   input  wire logic [7:0] pb_ext_en,
   output logic      [7:0] pb_in
);
   logic [7:0] pb_last_q;
   always_ff @(posedge clk) begin
      pb_last_q <= pb_in;
   end
   // driver beats keypad, keypad beats pull-up; no level is kept for free
   assign pa_in = (pa_oe & pa_out) | (~pa_oe & pa_ext);
   assign pb_in = (pb_oe & pb_out) | (~pb_oe & pb_ext_en & pb_ext)
                | (~pb_oe & ~pb_ext_en & (pb_pullup | ~pb_last_q));
endmodule : dpg_pin_model

// *** verif/dual_port_gpio_with_change_irq_bench.sv ***
// Purpose: register and pin tests of the dual gpio block
// Assumes: axi4-lite master, pins through the pin model
// Notes:   software reads the port before clearing the flag, except one clear that shows a persisting mismatch sets it again
`timescale 1ns/100ps
module dual_port_gpio_with_change_irq_bench;
   import dpg_pkg::*;
   logic        clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, sleep, wake, irq, master_clear_n;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rv;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rs;
   logic [7:0]  pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, pb_pullup;
   logic [7:0]  alt_out, alt_oe, pa_ext, pb_ext, pb_ext_en;
   int          err_total, comparisons, k, cnt;
   logic        prev;
   logic [7:0]  ri [6] = '{IDX_TRB, IDX_TRA, IDX_OPT, IDX_CMP, IDX_VREF, IDX_INTC};
   logic [7:0]  re [6] = '{8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};

   dpg_gpio uut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
      .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .pb_pullup(pb_pullup),
      .alt_out(alt_out), .alt_oe(alt_oe), .sleep(sleep), .wake(wake),
      .port_change_irq(irq), .master_clear_req(master_clear_n));
   dpg_pin_model pins (.clk(clk), .pa_out(pa_out), .pa_oe(pa_oe), .pa_ext(pa_ext),
      .pa_in(pa_in), .pb_out(pb_out), .pb_oe(pb_oe), .pb_pullup(pb_pullup),
      .pb_ext(pb_ext), .pb_ext_en(pb_ext_en), .pb_in(pb_in));

   always #4 clk = ~clk;

   task automatic results;
      $display("comparisons %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   function automatic logic [11:0] ba(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction : ba

   // handshakes are judged at the falling edge, acted on at the next rise
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      logic aw, w, b;
      int   n;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(negedge clk);
         aw = awvalid && awready;
         w  = wvalid && wready;
         b  = bvalid;
         rs = bresp;
         @(posedge clk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         if (b) begin
            bready <= 1'b0;
            break;
         end
      end
      if (n == 100) begin
         err_total++;
         results;
      end
   endtask : wr

   task automatic rd(input logic [11:0] a);
      logic ar, r;
      int   n;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(negedge clk);
         ar = arvalid && arready;
         r  = rvalid;
         rv = rdata;
         rs = rresp;
         @(posedge clk);
         if (ar) arvalid <= 1'b0;
         if (r) begin
            rready <= 1'b0;
            break;
         end
      end
      if (n == 100) begin
         err_total++;
         results;
      end
   endtask : rd

   task automatic wr8(input logic [7:0] idx, input logic [7:0] v);
      wr(ba(idx), {24'h0, v}, 4'h1);
      chk("bresp", 2'h0, rs);
   endtask : wr8

   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
      rd(ba(idx));
      chk("rdata", {24'h0, exp}, rv);
      chk("rresp", 2'h0, rs);
   endtask : rdc

   initial begin
      {clk, rst_n, awvalid, wvalid, bready, arvalid, rready, sleep} = '0;
      {awaddr, araddr, wdata, wstrb, alt_out, alt_oe} = '0;
      pa_ext    = 8'hff;
      pb_ext    = 8'h00;
      pb_ext_en = 8'hff;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      for (k = 0; k < 6; k++) rdc(ri[k], re[k]);
      @(negedge clk);
      chk("pullup", 8'h00, pb_pullup);
      chk("pb_oe", 8'h00, pb_oe);
      chk("pa_oe", 8'h00, pa_oe);
      rd(12'h3fc);
      chk("resp", 2'h3, rs);
      chk("rdata", 32'h0, rv);
      pb_ext <= 8'h30;
      wr(12'h618, 32'h0, 4'h1);
      chk("resp", 2'h3, rs);
      rdc(IDX_TRB, 8'hff);
      wr8(IDX_VREF, 8'hff);
      rdc(IDX_VREF, 8'hef);
      wr8(IDX_CMP, 8'hff);
      rdc(IDX_CMP, 8'h3f);
      wr8(IDX_CMP, 8'h00);
      rdc(IDX_PA, 8'hf0);
      wr8(IDX_CMP, 8'h07);
      rdc(IDX_PA, 8'hff);
      wr8(IDX_TRA, 8'h00);
      wr8(IDX_PA, 8'h10);
      @(negedge clk);
      chk("pa_oe", 8'h0f, pa_oe & 8'h3f);
      chk("pa_out", 8'h00, pa_out & 8'h1f);
      wr8(IDX_PA, 8'h00);
      @(negedge clk);
      chk("pa_oe4", 1'b1, pa_oe[4]);
      chk("pa_out4", 1'b0, pa_out[4]);
      wr8(IDX_TRA, 8'hff);
      wr8(IDX_CFG, 8'h01);
      pa_ext <= 8'hdf;
      repeat (4) @(posedge clk);
      chk("master_clear_n", 1'b1, master_clear_n);
      pa_ext <= 8'hff;
      wr8(IDX_CFG, 8'h02);
      @(negedge clk);
      chk("pa_oe6", 1'b1, pa_oe[6]);
      prev = pa_out[6];
      cnt  = 0;
      repeat (16) begin
         @(negedge clk);
         if (pa_out[6] && !prev) cnt++;
         prev = pa_out[6];
      end
      chk("qclk", 4, cnt);
      wr8(IDX_CFG, 8'h00);
      wr8(IDX_TRB, 8'hf0);
      wr8(IDX_PB, 8'ha5);
      @(negedge clk);
      chk("pb_oe", 8'h0f, pb_oe);
      chk("pb_out", 8'h05, pb_out & 8'h0f);
      rdc(IDX_PB, 8'h35);
      wr(ba(IDX_PB), 32'h0f0a, 4'h3);
      wr8(IDX_TRB, 8'h00);
      @(negedge clk);
      chk("pb_out", 8'h3a, pb_out);
      wr8(IDX_TRB, 8'hff);
      alt_out <= 8'h01;
      alt_oe  <= 8'h01;
      wr8(IDX_ALT, 8'h01);
      @(negedge clk);
      chk("alt_oe", 8'h01, pb_oe);
      chk("alt_out", 1'b1, pb_out[0]);
      wr8(IDX_ALT, 8'h00);
      wr8(IDX_TRB, 8'hf0);
      wr8(IDX_OPT, 8'h7f);
      @(negedge clk);
      chk("pullup", 8'hf0, pb_pullup);
      pb_ext_en <= 8'h0f;
      repeat (4) @(posedge clk);
      rdc(IDX_PB, 8'hfa);
      pb_ext_en <= 8'hff;
      wr8(IDX_OPT, 8'hff);
      wr8(IDX_TRB, 8'hff);
      pb_ext <= 8'h30;
      repeat (4) @(posedge clk);
      rd(ba(IDX_PB));
      wr8(IDX_INTC, 8'h08);
      pb_ext <= 8'h34;
      repeat (5) @(posedge clk);
      chk("irq", 1'b0, irq);
      pb_ext <= 8'h74;
      repeat (5) @(posedge clk);
      chk("irq", 1'b1, irq);
      wr8(IDX_INTC, 8'h08);
      rdc(IDX_INTC, 8'h09);
      rd(ba(IDX_PB));
      wr8(IDX_INTC, 8'h08);
      rdc(IDX_INTC, 8'h08);
      pb_ext <= 8'h34;
      sleep  <= 1'b1;
      repeat (5) @(posedge clk);
      chk("wake", 1'b1, wake);
      sleep   <= 1'b0;
      alt_oe  <= 8'h80;
      wr8(IDX_ALT, 8'h80);
      rd(ba(IDX_PB));
      wr8(IDX_INTC, 8'h08);
      alt_out <= 8'h80;
      repeat (5) @(posedge clk);
      chk("irq", 1'b0, irq);
      results;
   end
endmodule : dual_port_gpio_with_change_irq_bench
